// file: msl_pkg.sv
package msl_pkg;
  typedef enum logic [1:0] {
    MSL_NONE   = 2'b00,
    MSL_MASTER = 2'b01,
    MSL_SLAVE  = 2'b10
  } msl_mode_e;

  typedef enum logic [1:0] {
    MSL_SRC_SW  = 2'b00,
    MSL_SRC_EXT = 2'b01,
    MSL_SRC_THR = 2'b10
  } msl_src_e;

  typedef enum logic [1:0] {
    MSL_REF_NONE = 2'b00,
    MSL_REF_EXT  = 2'b01,
    MSL_REF_THR  = 2'b10,
    MSL_REF_LINK = 2'b11
  } msl_ref_e;

  typedef enum logic [1:0] {
    MSL_IDLE      = 2'b00,
    MSL_ARMED     = 2'b01,
    MSL_RUN       = 2'b10,
    MSL_STOP_WAIT = 2'b11
  } msl_state_e;

  localparam msl_mode_e   MSL_MODE_RST    = MSL_NONE;
  localparam int          MSL_RATE_W      = 16;
  localparam logic [15:0] MSL_BASE_DIV    = 16'h0004;
  localparam logic [15:0] MSL_RATE_RST    = 16'h0001;
  localparam longint      MSL_CLK_HZ      = 100_000_000;
  localparam longint      MSL_STOP_WAIT_S = 20;
  localparam logic [31:0] MSL_STOP_WAIT_CYC = 32'(MSL_STOP_WAIT_S * MSL_CLK_HZ);
endpackage

// file: msl_link_if.sv
`timescale 1ns/1ns
interface msl_link_if;
  logic dev_trig_o;
  logic dev_trig_oe;
  logic dev_clk_o;
  logic dev_clk_oe;
  logic peer_trig_o;
  logic peer_trig_oe;
  logic peer_clk_o;
  logic peer_clk_oe;
  logic trig;
  logic clk;

  // undriven link lines rest low
  assign trig = (dev_trig_oe & dev_trig_o) | (peer_trig_oe & peer_trig_o);
  assign clk  = (dev_clk_oe & dev_clk_o) | (peer_clk_oe & peer_clk_o);

  modport dev (output dev_trig_o, output dev_trig_oe, output dev_clk_o, output dev_clk_oe,
               input trig, input clk);
  modport peer (output peer_trig_o, output peer_trig_oe, output peer_clk_o,
                output peer_clk_oe, input trig, input clk);
endinterface

// file: msl_pacer.sv
`timescale 1ns/1ns
module msl_pacer #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  // pacing
  input  wire logic         restart,
  input  wire logic         tick,
  input  wire logic [W-1:0] div,
  output logic              pulse
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] last;

  // a divisor of zero behaves as one
  assign last = (div == '0) ? '0 : div - W'(1);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= '0;
    end else if (restart) begin
      cnt_r <= '0;
    end else if (tick) begin
      cnt_r <= (cnt_r >= last) ? '0 : cnt_r + W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pulse <= 1'b0;
    end else begin
      pulse <= !restart && tick && (cnt_r == '0);
    end
  end
endmodule

// file: msl_dev.sv
// Function
// - three sync modes: master, slave, none
// - master drives trigger and clock onto link
// - slave takes clock and trigger from link
// - slave ignores local start source, uses link
// - none is default, local clock, link unused
// - mode held until rewritten or application exits
// - master and slaves start within one conversion
// - each module has its own rate divisor
// - host arms slaves before starting master
// - slave armed after link trigger never starts
// - stop while slave waits takes twenty seconds
// - master stop does not stop slaves
// - host stops slaves before unplugging link
// - slave reference: threshold or link
// - master start sw/ext/thr, reference ext/thr
// - slave to older master refuses link reference
// - older peer slave takes one link start trigger
// - older peer start sw/ext/thr, reference threshold only
// - one clock, local or link, paces both input and output
// - slave external trigger pin is unusable
`timescale 1ns/1ns
module msl_dev #(
  parameter int          RATE_W        = msl_pkg::MSL_RATE_W,
  parameter logic [31:0] STOP_WAIT_CYC = msl_pkg::MSL_STOP_WAIT_CYC
) (
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst_b,
  // configuration
  input  wire logic                  mode_we,
  input  wire msl_pkg::msl_mode_e    mode_wdata,
  input  wire logic                  app_exit,
  input  wire msl_pkg::msl_src_e     start_src,
  input  wire msl_pkg::msl_ref_e     ref_src,
  input  wire logic                  old_peer,
  input  wire logic [RATE_W-1:0]     rate_div,
  // acquisition control
  input  wire logic                  arm,
  input  wire logic                  stop,
  input  wire logic                  sw_trig,
  input  wire logic                  ext_trig,
  input  wire logic                  thr_cross,
  // status
  output msl_pkg::msl_mode_e         mode_q,
  output msl_pkg::msl_state_e        state_q,
  output logic                       acq_run,
  output logic                       conv_pulse,
  output logic                       ao_pace,
  output logic                       ref_hit,
  output logic                       ref_done,
  output logic                       ref_refused,
  // link
  msl_link_if.dev                    link
);
  import msl_pkg::*;

  msl_mode_e  mode_r;
  msl_state_e state_r;
  msl_state_e state_nxt;
  logic [31:0] wait_cnt_r;
  logic        ext_q_r;
  logic        thr_q_r;
  logic        ltrig_q_r;
  logic        ref_done_r;
  logic        ref_hit_r;
  logic        is_master;
  logic        is_slave;
  logic        ext_rise;
  logic        thr_rise;
  logic        link_rise;
  logic        link_fall;
  logic        start_evt;
  logic        ref_evt;
  logic        base_tick;
  logic        src_tick;
  logic        wait_done;

  // mode register: legal writes only, exit returns to none
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mode_r <= MSL_MODE_RST;
    end else if (app_exit) begin
      mode_r <= MSL_NONE;
    end else if (mode_we && (mode_wdata != 2'b11)) begin
      mode_r <= mode_wdata;
    end
  end

  assign is_master = (mode_r == MSL_MASTER);
  assign is_slave  = (mode_r == MSL_SLAVE);

  // edge history of trigger inputs
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ext_q_r   <= 1'b0;
      thr_q_r   <= 1'b0;
      ltrig_q_r <= 1'b0;
    end else begin
      ext_q_r   <= ext_trig;
      thr_q_r   <= thr_cross;
      ltrig_q_r <= link.trig;
    end
  end

  assign ext_rise  = ext_trig & ~ext_q_r & ~is_slave;
  assign thr_rise  = thr_cross & ~thr_q_r;
  assign link_rise = is_slave & link.trig & ~ltrig_q_r;
  assign link_fall = is_slave & ~link.trig & ltrig_q_r;

  // local start source, not consulted in slave mode
  always_comb begin
    start_evt = 1'b0;
    unique case (start_src)
      MSL_SRC_SW:  start_evt = sw_trig;
      MSL_SRC_EXT: start_evt = ext_rise;
      MSL_SRC_THR: start_evt = thr_rise;
      default:     start_evt = 1'b0;
    endcase
  end

  // reference source; link reference only for a like master
  always_comb begin
    ref_evt = 1'b0;
    unique case (ref_src)
      MSL_REF_NONE: ref_evt = 1'b0;
      MSL_REF_EXT:  ref_evt = ext_rise;
      MSL_REF_THR:  ref_evt = thr_rise;
      MSL_REF_LINK: ref_evt = link_fall & ~old_peer;
      default:      ref_evt = 1'b0;
    endcase
  end

  assign ref_refused = (ref_src == MSL_REF_LINK) && (!is_slave || old_peer);

  assign wait_done = (wait_cnt_r >= STOP_WAIT_CYC - 32'h0000_0001);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      MSL_IDLE: begin
        if (arm) begin
          state_nxt = MSL_ARMED;
        end
      end
      MSL_ARMED: begin
        if (is_slave) begin
          // only a fresh rising edge starts a slave; a level already high is missed
          if (stop) begin
            state_nxt = MSL_STOP_WAIT;
          end else if (link_rise) begin
            state_nxt = MSL_RUN;
          end
        end else if (stop) begin
          state_nxt = MSL_IDLE;
        end else if (start_evt) begin
          state_nxt = MSL_RUN;
        end
      end
      MSL_STOP_WAIT: begin
        if (wait_done) begin
          state_nxt = MSL_IDLE;
        end
      end
      MSL_RUN: begin
        // a falling link trigger never ends a slave run
        if (stop) begin
          state_nxt = MSL_IDLE;
        end
      end
      default: state_nxt = MSL_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= MSL_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // stop delay counter for a slave still waiting
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wait_cnt_r <= 32'h0000_0000;
    end else if (state_r != MSL_STOP_WAIT) begin
      wait_cnt_r <= 32'h0000_0000;
    end else if (!wait_done) begin
      wait_cnt_r <= wait_cnt_r + 32'h0000_0001;
    end
  end

  // reference capture, sticky until the next arm
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ref_done_r <= 1'b0;
      ref_hit_r  <= 1'b0;
    end else begin
      ref_hit_r <= (state_r == MSL_RUN) && ref_evt && !ref_done_r;
      if ((state_r == MSL_RUN) && ref_evt) begin
        ref_done_r <= 1'b1;
      end else if (arm && (state_r == MSL_IDLE)) begin
        ref_done_r <= 1'b0;
      end
    end
  end

  // base rate from the system clock
  msl_pacer #(
    .W (RATE_W)
  ) u_base (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .restart (1'b0),
    .tick    (1'b1),
    .div     (RATE_W'(MSL_BASE_DIV)),
    .pulse   (base_tick)
  );

  // slaves pace from the link clock, others locally
  assign src_tick = is_slave ? link.clk : base_tick;

  // own divisor per module; restart aligns the first conversion to the start
  msl_pacer #(
    .W (RATE_W)
  ) u_conv (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .restart (state_r != MSL_RUN),
    .tick    (src_tick),
    .div     (rate_div),
    .pulse   (conv_pulse)
  );

  // master drives trigger as a level; dropped on reference or stop
  assign link.dev_trig_o  = (state_r == MSL_RUN) && !ref_done_r;
  assign link.dev_trig_oe = is_master;
  assign link.dev_clk_o   = base_tick;
  assign link.dev_clk_oe  = is_master;

  assign mode_q   = mode_r;
  assign state_q  = state_r;
  assign acq_run  = (state_r == MSL_RUN);
  assign ao_pace  = src_tick;
  assign ref_hit  = ref_hit_r;
  assign ref_done = ref_done_r;
endmodule

// file: msl_peer.sv
`timescale 1ns/1ns
module msl_peer #(
  parameter int RATE_W = msl_pkg::MSL_RATE_W
) (
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst_b,
  // configuration
  input  wire logic                  mode_we,
  input  wire msl_pkg::msl_mode_e    mode_wdata,
  input  wire msl_pkg::msl_src_e     start_src,
  input  wire logic [RATE_W-1:0]     rate_div,
  // acquisition control
  input  wire logic                  arm,
  input  wire logic                  stop,
  input  wire logic                  sw_trig,
  input  wire logic                  ext_trig,
  input  wire logic                  thr_cross,
  // status
  output msl_pkg::msl_mode_e         mode_q,
  output logic                       acq_run,
  output logic                       conv_pulse,
  output logic                       ref_hit,
  // link
  msl_link_if.peer                   link
);
  import msl_pkg::*;

  msl_mode_e  mode_r;
  msl_state_e state_r;
  logic       ext_q_r;
  logic       thr_q_r;
  logic       ltrig_q_r;
  logic       ref_hit_r;
  logic       start_evt;
  logic       thr_rise;
  logic       base_tick;
  logic       is_slave;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mode_r <= MSL_MODE_RST;
    end else if (mode_we && (mode_wdata != 2'b11)) begin
      mode_r <= mode_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ext_q_r   <= 1'b0;
      thr_q_r   <= 1'b0;
      ltrig_q_r <= 1'b0;
    end else begin
      ext_q_r   <= ext_trig;
      thr_q_r   <= thr_cross;
      ltrig_q_r <= link.trig;
    end
  end

  assign is_slave = (mode_r == MSL_SLAVE);
  assign thr_rise = thr_cross & ~thr_q_r;

  // a slave knows one link event only, taken as its start
  always_comb begin
    start_evt = 1'b0;
    if (is_slave) begin
      start_evt = link.trig & ~ltrig_q_r;
    end else begin
      unique case (start_src)
        MSL_SRC_SW:  start_evt = sw_trig;
        MSL_SRC_EXT: start_evt = ext_trig & ~ext_q_r;
        MSL_SRC_THR: start_evt = thr_rise;
        default:     start_evt = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= MSL_IDLE;
    end else begin
      unique case (state_r)
        MSL_IDLE:  if (arm) state_r <= MSL_ARMED;
        MSL_ARMED: begin
          if (stop) begin
            state_r <= MSL_IDLE;
          end else if (start_evt) begin
            state_r <= MSL_RUN;
          end
        end
        MSL_RUN:   if (stop) state_r <= MSL_IDLE;
        default:   state_r <= MSL_IDLE;
      endcase
    end
  end

  // reference is a threshold crossing only
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ref_hit_r <= 1'b0;
    end else begin
      ref_hit_r <= (state_r == MSL_RUN) && thr_rise;
    end
  end

  msl_pacer #(
    .W (RATE_W)
  ) u_base (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .restart (1'b0),
    .tick    (1'b1),
    .div     (RATE_W'(MSL_BASE_DIV)),
    .pulse   (base_tick)
  );

  msl_pacer #(
    .W (RATE_W)
  ) u_conv (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .restart (state_r != MSL_RUN),
    .tick    (is_slave ? link.clk : base_tick),
    .div     (rate_div),
    .pulse   (conv_pulse)
  );

  // as master it drives its single start trigger as a level while running
  assign link.peer_trig_o  = (state_r == MSL_RUN);
  assign link.peer_trig_oe = (mode_r == MSL_MASTER);
  assign link.peer_clk_o   = base_tick;
  assign link.peer_clk_oe  = (mode_r == MSL_MASTER);

  assign mode_q  = mode_r;
  assign acq_run = (state_r == MSL_RUN);
  assign ref_hit = ref_hit_r;
endmodule

// file: msl_link_properties.sv
`timescale 1ns/1ns
module msl_link_properties #(
  parameter logic [31:0] STOP_WAIT_CYC = 32'h32
) (
  // clock and reset
  input wire logic                clk_sys,
  input wire logic                rst_b,
  // link
  input wire logic                dev_trig_o,
  input wire logic                dev_trig_oe,
  input wire logic                dev_clk_o,
  input wire logic                dev_clk_oe,
  input wire logic                trig,
  // device status
  input wire msl_pkg::msl_mode_e  mode_q,
  input wire msl_pkg::msl_state_e state_q,
  input wire logic                acq_run
);
  import msl_pkg::*;

  logic [31:0] wait_cnt_r;

  // cycles spent in stop wait, cleared elsewhere
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wait_cnt_r <= 32'h0;
    end else if (state_q == MSL_STOP_WAIT) begin
      wait_cnt_r <= wait_cnt_r + 32'h1;
    end else begin
      wait_cnt_r <= 32'h0;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  mode_code_legal_a: assert property (mode_q != 2'h3)
    else $error("unused mode code held");
  reset_mode_none_a: assert property ($rose(rst_b) |->
    mode_q == MSL_NONE && state_q == MSL_IDLE && !dev_clk_oe)
    else $error("reset state wrong");
  master_drives_both_a: assert property (
    dev_clk_oe == (mode_q == MSL_MASTER) && dev_trig_oe == dev_clk_oe)
    else $error("link drive does not follow mode");
  link_clk_base_a: assert property (dev_clk_oe && dev_clk_o |=>
    (!dev_clk_o) [*3] ##1 (dev_clk_o || !dev_clk_oe))
    else $error("link clock not a base tick");
  master_start_trig_a: assert property (
    mode_q == MSL_MASTER && $rose(acq_run) |-> dev_trig_o)
    else $error("master start not on link");
  slave_link_start_a: assert property (
    mode_q == MSL_SLAVE && $rose(state_q == MSL_RUN) |-> $past(trig) && !$past(trig, 2))
    else $error("slave started without link edge");
  late_arm_idle_a: assert property (
    mode_q == MSL_SLAVE && state_q == MSL_ARMED && trig && $past(trig) |=> state_q != MSL_RUN)
    else $error("late slave started");
  stop_wait_len_a: assert property (
    $fell(state_q == MSL_STOP_WAIT) |-> wait_cnt_r == STOP_WAIT_CYC)
    else $error("stop wait length wrong");
  stop_wait_entry_a: assert property (
    $rose(state_q == MSL_STOP_WAIT) |-> $past(state_q) == MSL_ARMED && mode_q == MSL_SLAVE)
    else $error("stop wait entered wrongly");
endmodule

// file: multi_module_sync_link_tb.sv
`timescale 1ns/1ns
module multi_module_sync_link_tb;
  import msl_pkg::*;
  // shortened so the stop wait fits the run
  localparam logic [31:0] SW_CYC = 32'h32;
  // pl: 0 arm 1 stop 2 sw_trig 3 mode_we 4 app_exit 5 peer arm 6 stop 7 sw_trig 8 mode_we
  // clock starts low here so the clock process stays its only writer
  logic        clk_sys = 1'b0;
  logic        rst_b, old_peer, ext_trig, thr_cross, acq_run, conv_pulse, ao_pace;
  logic        ref_hit, ref_done, ref_refused, p_acq_run, p_conv_pulse, p_ref_hit;
  logic [8:0]  pl;
  logic [15:0] rate_div, p_rate_div;
  logic [31:0] seed;
  msl_mode_e   mode_wdata, p_mode_wdata, mode_q, p_mode_q;
  msl_src_e    start_src;
  msl_ref_e    ref_src;
  msl_state_e  state_q;
  int          fail_count, n_tests, n;

  always #5 clk_sys = ~clk_sys;

  msl_link_if msl_link_if_i ();
  msl_dev #(.STOP_WAIT_CYC(SW_CYC)) msl_dev_i (.clk_sys(clk_sys), .rst_b(rst_b),
    .mode_we(pl[3]), .mode_wdata(mode_wdata), .app_exit(pl[4]), .start_src(start_src),
    .ref_src(ref_src), .old_peer(old_peer), .rate_div(rate_div), .arm(pl[0]), .stop(pl[1]),
    .sw_trig(pl[2]), .ext_trig(ext_trig), .thr_cross(thr_cross), .mode_q(mode_q),
    .state_q(state_q), .acq_run(acq_run), .conv_pulse(conv_pulse), .ao_pace(ao_pace),
    .ref_hit(ref_hit), .ref_done(ref_done), .ref_refused(ref_refused), .link(msl_link_if_i));
  msl_peer msl_peer_i (.clk_sys(clk_sys), .rst_b(rst_b), .mode_we(pl[8]),
    .mode_wdata(p_mode_wdata), .start_src(MSL_SRC_SW), .rate_div(p_rate_div), .arm(pl[5]),
    .stop(pl[6]), .sw_trig(pl[7]), .ext_trig(1'b0), .thr_cross(thr_cross), .mode_q(p_mode_q),
    .acq_run(p_acq_run), .conv_pulse(p_conv_pulse), .ref_hit(p_ref_hit), .link(msl_link_if_i));
  msl_link_properties #(.STOP_WAIT_CYC(SW_CYC)) msl_link_properties_i (.clk_sys(clk_sys),
    .rst_b(rst_b), .dev_trig_o(msl_link_if_i.dev_trig_o),
    .dev_trig_oe(msl_link_if_i.dev_trig_oe), .dev_clk_o(msl_link_if_i.dev_clk_o),
    .dev_clk_oe(msl_link_if_i.dev_clk_oe), .trig(msl_link_if_i.trig), .mode_q(mode_q),
    .state_q(state_q), .acq_run(acq_run));

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic cyc(input int c);
    repeat (c) @(negedge clk_sys);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // idle cycle after each pulse keeps one assignment per time step
  task automatic pls(input logic [8:0] m);
    pl = m;
    cyc(1);
    pl = 9'h000;
    cyc(1);
  endtask

  task automatic sm(input msl_mode_e d, input msl_mode_e p);
    mode_wdata = d;
    p_mode_wdata = p;
    pls(9'h108);
  endtask

  function automatic logic probe(input int w);
    case (w)
      0: probe = conv_pulse;
      1: probe = acq_run;
      2: probe = ref_hit;
      4: probe = p_conv_pulse;
      default: probe = (state_q == MSL_IDLE);
    endcase
  endfunction

  task automatic wait_for(input int w, input int max);
    n = 0;
    while (probe(w) !== 1'b1) begin
      if (n >= max) begin
        chk(32'h0, 32'h1);
        test_done();
      end
      cyc(1);
      n++;
    end
  endtask

  function automatic logic [31:0] exp_per(input logic [15:0] d);
    exp_per = ((d == 16'h0) ? 32'h1 : 32'(d)) * 32'(MSL_BASE_DIV);
  endfunction

  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    rnd = (seed[15:0] & 16'h0007) + 16'h0001;
  endfunction

  task automatic per(input int w, input logic [15:0] d);
    wait_for(w, 400);
    cyc(1);
    wait_for(w, 400);
    chk(n + 1, exp_per(d));
  endtask

  initial begin
    {rst_b, old_peer, ext_trig, thr_cross, pl} = 13'h0000;
    mode_wdata = MSL_NONE;
    p_mode_wdata = MSL_NONE;
    start_src = MSL_SRC_SW;
    ref_src = MSL_REF_EXT;
    {fail_count, n_tests, seed} = {32'h0, 32'h0, 32'h9693};
    rate_div = rnd();
    p_rate_div = rnd();
    cyc(6);
    rst_b = 1'b1;
    cyc(1);
    chk(mode_q, MSL_NONE);
    chk(msl_link_if_i.dev_clk_oe | msl_link_if_i.dev_trig_oe, 32'h0);
    n = 0;
    repeat (40) begin
      cyc(1);
      if (ao_pace === 1'b1) n++;
    end
    chk(n, 32'hA);
    sm(MSL_MASTER, MSL_NONE);
    cyc(20);
    chk(mode_q, MSL_MASTER);
    for (int i = 0; i < 4; i++) begin
      sm(msl_mode_e'(2'(i)), MSL_NONE);
      chk(mode_q, (i == 3) ? 32'h2 : 32'(i));
    end
    mode_wdata = MSL_MASTER;
    pls(9'h018);
    chk(mode_q, MSL_NONE);
    // device leads, peer follows
    sm(MSL_MASTER, MSL_SLAVE);
    pls(9'h020);
    pls(9'h001);
    pls(9'h004);
    chk({acq_run, ref_done}, 32'h2);
    cyc(1);
    chk(p_acq_run, 32'h1);
    per(0, rate_div);
    per(4, p_rate_div);
    ext_trig = 1'b1;
    wait_for(2, 10);
    chk(ref_done, 32'h1);
    pls(9'h002);
    chk({acq_run, msl_link_if_i.trig}, 32'h0);
    cyc(8);
    chk(p_acq_run, 32'h1);
    pls(9'h040);
    chk(p_acq_run, 32'h0);
    // older peer leads, device follows
    old_peer = 1'b1;
    ext_trig = 1'b0;
    ref_src = MSL_REF_LINK;
    sm(MSL_SLAVE, MSL_MASTER);
    chk(ref_refused, 32'h1);
    chk(p_mode_q, MSL_MASTER);
    ref_src = MSL_REF_THR;
    cyc(1);
    chk({ref_refused, msl_link_if_i.dev_clk_oe}, 32'h0);
    pls(9'h001);
    pls(9'h020);
    // a fresh pin edge with the pin selected must still not start a slave
    start_src = MSL_SRC_EXT;
    ext_trig = 1'b1;
    pls(9'h004);
    cyc(3);
    chk(acq_run, 32'h0);
    pls(9'h080);
    wait_for(1, 6);
    chk(32'(n < 4), 32'h1);
    per(0, rate_div);
    thr_cross = 1'b1;
    wait_for(2, 10);
    chk({ref_done, p_ref_hit}, 32'h3);
    pls(9'h002);
    chk(state_q, MSL_IDLE);
    // link trigger already high when armed
    pls(9'h001);
    cyc(10);
    chk(state_q, MSL_ARMED);
    pls(9'h002);
    chk(state_q, MSL_STOP_WAIT);
    wait_for(3, 200);
    chk(n + 1, SW_CYC);
    // reset in mid-run while the peer still drives the link
    rst_b = 1'b0;
    cyc(2);
    chk({p_acq_run, msl_link_if_i.trig}, 32'h0);
    rst_b = 1'b1;
    cyc(1);
    chk(mode_q, MSL_NONE);
    pls(9'h040);
    test_done();
  end
endmodule
